/* rtl/rbp_defines.svh */
// register offsets, field positions and reset values of the read path
`ifndef RBP_DEFINES_SVH
`define RBP_DEFINES_SVH

// ==========================================================
// register byte offsets
`define RBP_OFF_LAT 8'h00
`define RBP_OFF_MODE 8'h04
`define RBP_OFF_TIM 8'h08
`define RBP_OFF_STAT 8'h0c
`define RBP_OFF_MWGAP 8'h10

// ==========================================================
// reset values and writable masks
`define RBP_LAT_RST 32'h00000414
`define RBP_LAT_MASK 32'h00000f3f
`define RBP_MODE_RST 32'h000000a4
`define RBP_MODE_MASK 32'h000000ff
`define RBP_TIM_RST 32'h00008210
`define RBP_TIM_MASK 32'h0000ffff

// ==========================================================
// field positions
`define RBP_LAT_RL_LSB 0
`define RBP_LAT_CRC_READ_LATENCY_LSB 8
`define RBP_MODE_CRC_BIT 0
`define RBP_MODE_INVDIS_BIT 1
`define RBP_MODE_ODT_BIT 2
`define RBP_MODE_HALF_BIT 3
`define RBP_MODE_HOLD_LSB 4
`define RBP_TIM_RAS_LSB 0
`define RBP_TIM_RTP_LSB 8
`define RBP_TIM_CCD_LSB 12

// ==========================================================
// burst and link timing
`define RBP_BURST_BEATS 16
`define RBP_DBI_ZERO_LIMIT 4
`define RBP_CMD_IDLE 14'h3000

`endif

/* rtl/rbp_pkg.sv */
// types shared by the read path modules
package rbp_pkg;

    localparam int RBP_BANKS = 16;

    typedef enum logic [1:0] {
        RBP_IDLE,
        RBP_BURST,
        RBP_TAIL
    } rbp_state_t;

    typedef struct packed {
        logic [15:0] due;
        logic [3:0] bank;
        logic [5:0] col;
        logic ce;
    } rbp_entry_t;

endpackage

/* rtl/rbp_q_if.sv */
// carrier between the read path and its pending-read store
`timescale 1ns/1ps
interface rbp_q_if
    import rbp_pkg::*;
();
    logic push;
    rbp_entry_t wdata;
    logic pop;
    rbp_entry_t head;
    logic empty;
    logic full;

    modport owner (output push, wdata, pop, input head, empty, full);
    modport store (input push, wdata, pop, output head, empty, full);
endinterface

/* rtl/rbp_queue.sv */
// small memory of pending reads with a registered head
`timescale 1ns/1ps
module rbp_queue
    import rbp_pkg::*;
#(
    parameter int DEPTH = 4
)
(
    input wire logic aclk,
    input wire logic aresetn,
    rbp_q_if.store q
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // ==========================================================
    // elaboration check
    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH)
        begin : g_bad
            $error("depth must be a power of two, 2 or more");
        end
    endgenerate

    rbp_entry_t mem_r [DEPTH];
    logic [AW:0] wr_ptr_r;
    logic [AW:0] rd_ptr_r;
    rbp_entry_t head_r;
    logic do_push;
    logic do_pop;

    assign q.empty = (wr_ptr_r == rd_ptr_r);
    assign q.full = (wr_ptr_r[AW] != rd_ptr_r[AW])
        && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
    assign do_push = q.push && !q.full;
    assign do_pop = q.pop && !q.empty;
    assign q.head = head_r;

    // ==========================================================
    // storage
    always_ff @(posedge aclk)
    begin
        if (do_push)
        begin
            mem_r[wr_ptr_r[AW-1:0]] <= q.wdata;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end
        else
        begin
            if (do_push)
            begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (do_pop)
            begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
        end
    end

    // head lags pointers a cycle; reads come far apart
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            head_r <= '0;
        end
        else
        begin
            head_r <= mem_r[rd_ptr_r[AW-1:0]];
        end
    end
endmodule

/* rtl/rbp_read_path.sv */
// read burst path of a graphics dram channel
// Function
// - no internal read-modify-write: masked gap equals column spacing
// - auto precharge after read-to-precharge time and row active count
// - each read gives sixteen beats, never cut short
// - execute flag low: no access, no data, hold pattern
// - first beat base read latency periods after read
// - after last burst drive ones, termination on within one tck
// - termination off: lines undriven after a burst
// - read at minimum spacing continues data with no gap
// - inversion flag high for true, low for inverted, per byte
// - inversion on when disable bit 0, off when 1
// - crc on error pin at base plus crc read latency
// - error pin has full-rate and half-rate formats
// - auto precharge at earliest explicit precharge time
`timescale 1ns/1ps
`include "rbp_defines.svh"
module rbp_read_path
    import rbp_pkg::*;
#(
    parameter int QDEPTH = 4,
    parameter int MAX_CRC_READ_LATENCY = 15
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic link_clk,
    input wire logic cmd_read_n,
    input wire logic cmd_act_n,
    input wire logic cmd_ap_ca,
    input wire logic cmd_ce,
    input wire logic [3:0] cmd_bank,
    input wire logic [5:0] cmd_col,
    output logic array_rd_en,
    output logic [13:0] array_addr,
    input wire logic [15:0] array_rd_data,
    output logic [15:0] dq_o,
    output logic dq_oe_n,
    output logic [1:0] inversion_flag_o,
    output logic [1:0] error_detect_pin_o,
    output logic odt_on,
    output logic [RBP_BANKS-1:0] precharge_o
);
    localparam int DL = 2 * MAX_CRC_READ_LATENCY;

    generate
        if (QDEPTH < 2 || MAX_CRC_READ_LATENCY < 1 || MAX_CRC_READ_LATENCY > 15)
        begin : g_bad
            $error("bad queue depth or crc latency");
        end
    endgenerate

    function automatic logic [8:0] rbp_dbi(input logic [7:0] d,
        input logic en);
        int zeros;
        zeros = 0;
        for (int i = 0; i < 8; i++)
        begin
            zeros = zeros + ((d[i] == 1'b0) ? 1 : 0);
        end
        if (en && zeros > `RBP_DBI_ZERO_LIMIT)
        begin
            return {1'b0, ~d};
        end
        return {1'b1, d};
    endfunction

    function automatic logic [31:0] rbp_wr(input logic [31:0] old,
        input logic [31:0] d, input logic [3:0] strb, input logic [31:0] m);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r & m;
    endfunction

    // ==========================================================
    // register file
    logic [31:0] lat_r, mode_r, tim_r;
    logic [7:0] aw_addr_r;
    logic aw_full_r, w_full_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic [15:0] burst_cnt_r;
    logic [5:0] base_rl;
    logic [3:0] crc_read_latency, rtp_time, ccd;
    logic [7:0] ras_cycles;
    logic crc_en, inv_en, odt_en, half_rate;
    logic [3:0] hold_pat;
    logic [31:0] stat_word;
    logic q_full;

    assign base_rl = lat_r[`RBP_LAT_RL_LSB +: 6];
    assign crc_read_latency = lat_r[`RBP_LAT_CRC_READ_LATENCY_LSB +: 4];
    assign crc_en = mode_r[`RBP_MODE_CRC_BIT];
    assign inv_en = !mode_r[`RBP_MODE_INVDIS_BIT];
    assign odt_en = mode_r[`RBP_MODE_ODT_BIT];
    assign half_rate = mode_r[`RBP_MODE_HALF_BIT];
    assign hold_pat = mode_r[`RBP_MODE_HOLD_LSB +: 4];
    assign ras_cycles = tim_r[`RBP_TIM_RAS_LSB +: 8];
    assign rtp_time = tim_r[`RBP_TIM_RTP_LSB +: 4];
    assign ccd = tim_r[`RBP_TIM_CCD_LSB +: 4];

    assign s_axi_awready = !aw_full_r;
    assign s_axi_wready = !w_full_r;
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h00000000;
            w_strb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            lat_r <= `RBP_LAT_RST;
            mode_r <= `RBP_MODE_RST;
            tim_r <= `RBP_TIM_RST;
        end
        else
        begin
            if (s_axi_awvalid && !aw_full_r)
            begin
                aw_full_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_full_r)
            begin
                w_full_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
            if (aw_full_r && w_full_r && !s_axi_bvalid)
            begin
                aw_full_r <= 1'b0;
                w_full_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= 2'h0;
                case ({aw_addr_r[7:2], 2'b00})
                    `RBP_OFF_LAT: lat_r <= rbp_wr(lat_r, w_data_r,
                        w_strb_r, `RBP_LAT_MASK);
                    `RBP_OFF_MODE: mode_r <= rbp_wr(mode_r, w_data_r,
                        w_strb_r, `RBP_MODE_MASK);
                    `RBP_OFF_TIM: tim_r <= rbp_wr(tim_r, w_data_r,
                        w_strb_r, `RBP_TIM_MASK);
                    `RBP_OFF_STAT, `RBP_OFF_MWGAP: ;
                    default: s_axi_bresp <= 2'h2;
                endcase
            end
        end
    end

    rbp_state_t state_r;

    assign stat_word = {14'h0000, q_full, (state_r != RBP_IDLE),
        burst_cnt_r};

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h0;
        end
        else if (s_axi_rvalid)
        begin
            if (s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
        else if (s_axi_arvalid)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            case ({s_axi_araddr[7:2], 2'b00})
                `RBP_OFF_LAT: s_axi_rdata <= lat_r;
                `RBP_OFF_MODE: s_axi_rdata <= mode_r;
                `RBP_OFF_TIM: s_axi_rdata <= tim_r;
                `RBP_OFF_STAT: s_axi_rdata <= stat_word;
                // no internal read-modify-write, so gap is column spacing
                `RBP_OFF_MWGAP: s_axi_rdata <= {28'h0000000, ccd};
                default:
                begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= 2'h2;
                end
            endcase
        end
    end

    // ==========================================================
    // link sampling
    logic [2:0] lclk_sync_r;
    logic [13:0] cmd_s1_r, cmd_s2_r;
    logic rise_ev, fall_ev, beat_ev;
    logic s_read_n, s_act_n, s_ap, s_ce;
    logic [3:0] s_bank;
    logic [5:0] s_col;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            lclk_sync_r <= 3'h0;
            cmd_s1_r <= `RBP_CMD_IDLE;
            cmd_s2_r <= `RBP_CMD_IDLE;
        end
        else
        begin
            lclk_sync_r <= {lclk_sync_r[1:0], link_clk};
            cmd_s1_r <= {cmd_read_n, cmd_act_n, cmd_ap_ca, cmd_ce,
                cmd_bank, cmd_col};
            cmd_s2_r <= cmd_s1_r;
        end
    end

    assign rise_ev = lclk_sync_r[1] && !lclk_sync_r[2];
    assign fall_ev = !lclk_sync_r[1] && lclk_sync_r[2];
    assign beat_ev = rise_ev || fall_ev;
    assign {s_read_n, s_act_n, s_ap, s_ce, s_bank, s_col} = cmd_s2_r;

    // ==========================================================
    // command capture and scheduling
    rbp_q_if q ();
    logic [15:0] tck_cnt_r;
    logic [15:0] slack;
    logic rd_acc, start_ok, ap_wait_r;
    logic [3:0] ap_bank_r;
    logic [3:0] beat_r, cur_bank_r;
    logic [5:0] cur_col_r;
    logic cur_ce_r;

    rbp_queue #(.DEPTH(QDEPTH)) u_queue (
        .aclk(aclk),
        .aresetn(aresetn),
        .q(q.store)
    );

    assign q_full = q.full;
    assign rd_acc = rise_ev && !s_read_n;
    assign q.push = rd_acc;
    // first beat after base latency
    assign q.wdata = '{due: tck_cnt_r + {10'h000, base_rl},
        bank: s_bank, col: s_col, ce: s_ce};
    assign slack = tck_cnt_r - q.head.due;
    // start only at a burst boundary
    assign start_ok = rise_ev && !q.empty && !slack[15]
        && (state_r != RBP_BURST || beat_r == 4'hf);
    assign q.pop = start_ok;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tck_cnt_r <= 16'h0000;
            ap_wait_r <= 1'b0;
            ap_bank_r <= 4'h0;
        end
        else
        begin
            if (rise_ev)
            begin
                tck_cnt_r <= tck_cnt_r + 16'h0001;
            end
            if (rd_acc)
            begin
                ap_wait_r <= 1'b1;
                ap_bank_r <= s_bank;
            end
            else if (fall_ev)
            begin
                ap_wait_r <= 1'b0;
            end
        end
    end

    // ==========================================================
    // burst sequencer
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_r <= RBP_IDLE;
            beat_r <= 4'h0;
            cur_bank_r <= 4'h0;
            cur_col_r <= 6'h00;
            cur_ce_r <= 1'b0;
            burst_cnt_r <= 16'h0000;
        end
        else if (start_ok)
        begin
            state_r <= RBP_BURST;
            beat_r <= 4'h0;
            cur_bank_r <= q.head.bank;
            cur_col_r <= q.head.col;
            cur_ce_r <= q.head.ce;
            burst_cnt_r <= burst_cnt_r + 16'h0001;
        end
        else
        begin
            case (state_r)
                RBP_BURST:
                begin
                    if (rise_ev && beat_r == 4'hf)
                    begin
                        // drive ones only if termination follows
                        state_r <= odt_en ? RBP_TAIL : RBP_IDLE;
                    end
                    else if (beat_ev && beat_r != 4'hf)
                    begin
                        beat_r <= beat_r + 4'h1;
                    end
                end
                RBP_TAIL:
                begin
                    if (rise_ev)
                    begin
                        state_r <= RBP_IDLE;
                    end
                end
                default: state_r <= RBP_IDLE;
            endcase
        end
    end

    // ==========================================================
    // array fetch and output drive
    logic ev_d_r;
    logic [8:0] enc [2];
    logic [1:0] par;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            array_rd_en <= 1'b0;
            array_addr <= 14'h0000;
            ev_d_r <= 1'b0;
        end
        else
        begin
            ev_d_r <= beat_ev;
            // no array access without execute
            array_rd_en <= start_ok ? q.head.ce
                : (beat_ev && state_r == RBP_BURST && beat_r != 4'hf
                && cur_ce_r);
            if (start_ok)
            begin
                array_addr <= {q.head.bank, q.head.col, 4'h0};
            end
            else if (beat_ev && state_r == RBP_BURST)
            begin
                array_addr <= {cur_bank_r, cur_col_r, beat_r + 4'h1};
            end
        end
    end

    generate
        for (genvar l = 0; l < 2; l++)
        begin : g_lane
            assign enc[l] = rbp_dbi(array_rd_data[l*8 +: 8], inv_en);
            assign par[l] = ^enc[l];
        end
    endgenerate

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            dq_o <= 16'hffff;
            inversion_flag_o <= 2'h3;
            dq_oe_n <= 1'b1;
            odt_on <= 1'b0;
        end
        else if (array_rd_en)
        begin
            dq_o <= {enc[1][7:0], enc[0][7:0]};
            inversion_flag_o <= {enc[1][8], enc[0][8]};
            dq_oe_n <= 1'b0;
            odt_on <= 1'b0;
        end
        else if (ev_d_r)
        begin
            dq_o <= 16'hffff;
            inversion_flag_o <= 2'h3;
            dq_oe_n <= (state_r != RBP_TAIL);
            odt_on <= odt_en && state_r != RBP_TAIL
                && !(state_r == RBP_BURST && cur_ce_r);
        end
    end

    // ==========================================================
    // error detect pin
    // parity stands in for crc: cheap, beat-aligned
    logic [DL*4-1:0] dl_r;
    logic [3:0] rec, tapv;
    logic [1:0] hidx_r;
    int tap;

    assign rec = {array_rd_en && crc_en, !beat_r[0], par};
    assign tap = 2 * ((crc_read_latency == 4'h0) ? 1
        : ((int'(crc_read_latency) > MAX_CRC_READ_LATENCY) ? MAX_CRC_READ_LATENCY : int'(crc_read_latency))) - 1;
    assign tapv = dl_r[tap*4 +: 4];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            dl_r <= '0;
            hidx_r <= 2'h0;
            error_detect_pin_o <= 2'h0;
        end
        else if (ev_d_r)
        begin
            dl_r <= {dl_r[DL*4-5:0], rec};
            if (tapv[3] && (!half_rate || tapv[2]))
            begin
                error_detect_pin_o <= tapv[1:0];
            end
            else if (!tapv[3])
            begin
                // slots with no crc beat send hold pattern; skipped half-rate crc slots keep the last value
                error_detect_pin_o <= {2{hold_pat[hidx_r]}};
                hidx_r <= hidx_r + 2'h1;
            end
        end
    end

    // ==========================================================
    // auto precharge per bank
    generate
        for (genvar b = 0; b < RBP_BANKS; b++)
        begin : g_bank
            logic [7:0] ras_r;
            logic [3:0] rtp_r;
            logic pend_r, pre_r, fire, ap_ev;

            assign ap_ev = fall_ev && ap_wait_r && s_ap
                && ap_bank_r == 4'(b);
            assign fire = pend_r && rtp_r == 4'h0 && ras_r >= ras_cycles;
            assign precharge_o[b] = pre_r;

            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    ras_r <= 8'h00;
                    rtp_r <= 4'h0;
                    pend_r <= 1'b0;
                    pre_r <= 1'b0;
                end
                else
                begin
                    pre_r <= fire;
                    if (rise_ev && !s_act_n && s_bank == 4'(b))
                    begin
                        ras_r <= 8'h00;
                    end
                    else if (rise_ev && ras_r != 8'hff)
                    begin
                        ras_r <= ras_r + 8'h01;
                    end
                    if (rd_acc && s_bank == 4'(b))
                    begin
                        rtp_r <= rtp_time;
                    end
                    else if (rise_ev && rtp_r != 4'h0)
                    begin
                        rtp_r <= rtp_r - 4'h1;
                    end
                    // a new request in the firing cycle is kept
                    if (ap_ev)
                    begin
                        pend_r <= 1'b1;
                    end
                    else if (fire)
                    begin
                        pend_r <= 1'b0;
                    end
                end
            end
        end
    endgenerate
endmodule

/* sim/rbp_ctrl_model.sv */
// memory controller stand-in: command clock, commands, array data
`timescale 1ns/1ps
module rbp_ctrl_model
(
    input wire logic aclk,
    output logic link_clk,
    output logic cmd_read_n,
    output logic cmd_act_n,
    output logic cmd_ap_ca,
    output logic cmd_ce,
    output logic [3:0] cmd_bank,
    output logic [5:0] cmd_col,
    input wire logic [13:0] array_addr,
    output logic [15:0] array_rd_data
);
    // ==========================================
    // command clock runs free, as a command clock does
    initial
    begin
        link_clk = 1'b0;
        {cmd_read_n, cmd_act_n, cmd_ap_ca, cmd_ce} = 4'hd;
        cmd_bank = 4'h0;
        cmd_col = 6'h00;
    end
    always #80 link_clk = ~link_clk;
    assign array_rd_data = {array_addr[7:0], ~array_addr[7:0]};
    // no writes or precharges sent, so their spacing holds
    task automatic issue(input logic rd, input logic [3:0] b,
        input logic [5:0] c, input logic ap, input logic ce);
        @(negedge link_clk);
        @(posedge aclk);
        cmd_read_n <= !rd;
        cmd_act_n <= rd;
        {cmd_bank, cmd_col, cmd_ap_ca, cmd_ce} <= {b, c, ap, ce};
        @(posedge link_clk);
        @(posedge aclk);
        {cmd_read_n, cmd_act_n} <= 2'h3;
        @(negedge link_clk);
        @(posedge aclk);
        // released lines flip so a stale value is never mistaken
        {cmd_bank, cmd_col, cmd_ap_ca} <= ~{b, c, ap};
    endtask
endmodule

/* sim/rbp_read_path_checker.sv */
// port-level assertions for the read burst path
`timescale 1ns/1ps
module rbp_checker
    import rbp_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic array_rd_en,
    input wire logic [13:0] array_addr,
    input wire logic [15:0] dq_o,
    input wire logic dq_oe_n,
    input wire logic [1:0] inversion_flag_o,
    input wire logic odt_on,
    input wire logic [RBP_BANKS-1:0] precharge_o
);
    // ==========================================
    // beat tracking
    logic [3:0] beat_r;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            beat_r <= 4'h0;
        else if (array_rd_en)
            beat_r <= beat_r + 4'h1;
    end
    beat_addr_a: assert property (
        array_rd_en |-> array_addr[3:0] == beat_r)
        else $error("beat index out of order");
    beat_next_a: assert property (
        array_rd_en && array_addr[3:0] != 4'hf |-> ##[6:10] array_rd_en)
        else $error("burst cut short");
    beat_drive_a: assert property (array_rd_en |=> !dq_oe_n)
        else $error("beat not driven");
    odt_off_a: assert property (!dq_oe_n |-> !odt_on)
        else $error("termination on while driving");
    inv_low_a: assert property (
        !dq_oe_n && !inversion_flag_o[0] |-> $countones(dq_o[7:0]) > 4)
        else $error("byte0 flag wrong");
    inv_high_a: assert property (
        !dq_oe_n && !inversion_flag_o[1] |-> $countones(dq_o[15:8]) > 4)
        else $error("byte1 flag wrong");
    ap_pulse_a: assert property (
        |precharge_o |=> (precharge_o & $past(precharge_o)) == 16'h0)
        else $error("precharge not a pulse");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    cover property (array_rd_en && array_addr[3:0] == 4'hf);
    cover property (|precharge_o);
    cover property (!dq_oe_n && !inversion_flag_o[0]);
endmodule

/* sim/rbp_read_path_tb_top.sv */
// bench for the read burst path
`timescale 1ns/1ps
module sgram_read_burst_path_tb_top
    import rbp_pkg::*;
;
    logic aclk = 1'b0, aresetn = 1'b0, link_clk, cmd_read_n, cmd_act_n;
    logic cmd_ap_ca, cmd_ce, array_rd_en, dq_oe_n, odt_on, en_d = 1'b0;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, inversion_flag_o, error_detect_pin_o;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb, cmd_bank;
    logic [5:0] cmd_col;
    logic [13:0] array_addr;
    logic [15:0] array_rd_data, dq_o;
    logic [RBP_BANKS-1:0] precharge_o;
    logic [17:0] beats[$];
    logic [17:0] last;
    time beat_t = 0, gap_max = 0;
    int err_total = 0, checks = 0, pre_cnt = 0;
    always #5 aclk = ~aclk;
    rbp_read_path dut_u (.*);
    rbp_ctrl_model ctl_u (.*);
    // ==========================================
    // beat capture: data lands one cycle after each array strobe
    always @(posedge aclk)
    begin
        if (en_d)
            beats.push_back({inversion_flag_o, dq_o});
        if (!dq_oe_n)
            last <= {inversion_flag_o, dq_o};
        if (array_rd_en && beat_t > 0 && $time - beat_t > gap_max)
            gap_max = $time - beat_t;
        if (array_rd_en)
            beat_t = $time;
        if (precharge_o[3])
            pre_cnt++;
        en_d <= array_rd_en;
    end
    task automatic chk(input logic ok);
        checks++;
        if (!ok)
        begin
            err_total++;
            $display("[ERR] %0t mismatch", $time);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
        input logic [1:0] er);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        do
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk({s_axi_rresp, s_axi_rdata} === {er, e});
    endtask
    function automatic logic [8:0] enc(input logic [7:0] b, input logic inv);
        enc = (inv && $countones(b) < 4) ? {1'b0, ~b} : {1'b1, b};
    endfunction
    task automatic burst(input logic [5:0] c, input logic inv);
        logic [8:0] e1, e0;
        int k;
        for (k = 0; k < 3000 && beats.size() < 16; k++)
            @(posedge aclk);
        for (k = 0; k < 16; k++)
        begin
            e1 = enc({c[3:0], k[3:0]}, inv);
            e0 = enc(~{c[3:0], k[3:0]}, inv);
            chk(beats.pop_front() === {e1[8], e0[8], e1[7:0], e0[7:0]});
        end
    endtask
    task automatic idle();
        int k;
        for (k = 0; k < 400 && dq_oe_n !== 1'b1; k++)
            @(posedge aclk);
        @(posedge aclk);
    endtask
    task automatic final_report();
        $display("errors %0d checks %0d", err_total, checks);
        if (err_total == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        #400000;
        err_total++;
        final_report();
    end
    initial
    begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
        {s_axi_wdata, s_axi_wstrb} = 36'hf;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'h00, 32'h414, 2'h0);
        rd(8'h04, 32'ha4, 2'h0);
        rd(8'h08, 32'h8210, 2'h0);
        rd(8'h10, 32'h8, 2'h0);
        rd(8'h40, 32'h0, 2'h2);
        wr(8'h00, 32'h402);
        rd(8'h00, 32'h402, 2'h0);
        $display("registers done");
        ctl_u.issue(1'b0, 4'h3, 6'h00, 1'b0, 1'b1);
        repeat (2) @(posedge link_clk);
        ctl_u.issue(1'b1, 4'h3, 6'h05, 1'b1, 1'b1);
        repeat (7) @(posedge link_clk);
        ctl_u.issue(1'b1, 4'h3, 6'h06, 1'b0, 1'b1);
        burst(6'h05, 1'b1);
        burst(6'h06, 1'b1);
        idle();
        chk({last, odt_on} === 19'h7ffff);
        chk(gap_max <= 90);
        repeat (20) @(posedge link_clk);
        chk(pre_cnt == 1);
        $display("burst test done");
        wr(8'h04, 32'h000000a2);
        ctl_u.issue(1'b0, 4'h3, 6'h00, 1'b0, 1'b1);
        repeat (2) @(posedge link_clk);
        ctl_u.issue(1'b1, 4'h3, 6'h07, 1'b0, 1'b0);
        repeat (24) @(posedge link_clk);
        chk(beats.size() == 0 && dq_oe_n === 1'b1);
        ctl_u.issue(1'b1, 4'h3, 6'h07, 1'b0, 1'b1);
        burst(6'h07, 1'b0);
        idle();
        chk({last, odt_on} === {18'h37f80, 1'b0});
        $display("mode test done");
        final_report();
    end
endmodule
bind rbp_read_path rbp_checker chk_u (.*);
